// ### rdc_defines.svh
// Purpose: constants of the redriver configuration and detect control
// Assumes: 10 MHz system clock
// Notes: times are in ms, cycle counts are derived in the top module
`ifndef RDC_DEFINES_SVH
`define RDC_DEFINES_SVH

// four-level strap codes
`define RDC_LVL_L0 2'h0
`define RDC_LVL_L1 2'h1
`define RDC_LVL_L2 2'h2
`define RDC_LVL_L3 2'h3

// smbus addressing (8-bit address bytes)
`define RDC_EEPROM_ADDR 8'hA0
`define RDC_SLAVE_BASE 8'h30
`define RDC_EE_HDR_ADDR 8'h00

// eeprom image layout
`define RDC_HDR_COMMON_BIT 0
`define RDC_EQ_LSB 0

// timing, printed figures
`define RDC_CLK_HZ 10000000
`define RDC_POR_MS 30
`define RDC_LOAD_COMMON_MS 4
`define RDC_LOAD_NONCOMMON_MS 7

// reset values
`define RDC_EQ_RESET 4'h0
`define RDC_ADDR_RESET 8'h00

`endif

// ### rdc_pkg.sv
// Purpose: types shared by the redriver control modules
// Assumes: rdc_defines.svh holds the numbers
// Notes: none
package rdc_pkg;

	// configuration source chosen by the source strap
	typedef enum logic [1:0] {
		RDC_SRC_PIN = 2'b00,
		RDC_SRC_EEPROM = 2'b01,
		RDC_SRC_SLAVE = 2'b10
	} rdc_src_t;

	// eeprom self-load sequencer
	typedef enum logic [2:0] {
		RDC_EE_IDLE = 3'b000,
		RDC_EE_HDR = 3'b001,
		RDC_EE_DATA = 3'b010,
		RDC_EE_DONE = 3'b011,
		RDC_EE_FAIL = 3'b100,
		RDC_EE_OFF = 3'b101
	} rdc_ee_state_t;

	// receiver detect per channel
	typedef enum logic [1:0] {
		RDC_DET_IDLE = 2'b00,
		RDC_DET_PROBE = 2'b01,
		RDC_DET_DONE = 2'b10
	} rdc_det_state_t;

	// byte read request toward the smbus master engine
	typedef struct packed {
		logic valid;
		logic [7:0] devAddr;
		logic [7:0] byteAddr;
	} rdc_ee_req_t;

	// byte read answer from the smbus master engine
	typedef struct packed {
		logic ack;
		logic [7:0] data;
	} rdc_ee_rsp_t;

	// one register write from the smbus slave port
	typedef struct packed {
		logic valid;
		logic [1:0] chan;
		logic [3:0] eq;
		logic detTrig;
	} rdc_slv_wr_t;

endpackage

// ### rdc_rx_detect.sv
// Purpose: receiver detect for one channel, on the link clock
// Assumes: mode is static once power-on reset has completed
// Notes: start arrives as a toggle, standby and mode as levels
`timescale 1ns/1ps
`include "rdc_defines.svh"
module rdc_rx_detect (
	// link clock and reset
	input wire logic clk_link,
	input wire logic arst_n,
	// from the system domain
	input wire logic startTgl,
	input wire logic standby,
	input wire logic [1:0] detMode,
	// analog probe results, link domain
	input wire logic attempt,
	input wire logic found,
	// results, link domain
	output logic termOn,
	output logic present
);
	import rdc_pkg::*;

	logic [2:0] tglSync_reg; // two stages plus edge history
	logic [1:0] sbySync_reg;
	logic [1:0] modeMeta_reg;
	logic [1:0] mode_reg;
	logic [1:0] hits_reg;
	logic [1:0] need;
	logic startPulse;
	logic enabled;
	rdc_det_state_t state_reg;

	// crossings: first stage feeds only the second
	always_ff @(posedge clk_link or negedge arst_n) begin
		if (!arst_n) begin
			tglSync_reg <= 3'h0;
			sbySync_reg <= 2'h3;
			modeMeta_reg <= `RDC_LVL_L0;
			mode_reg <= `RDC_LVL_L0;
		end else begin
			tglSync_reg <= {tglSync_reg[1:0], startTgl};
			sbySync_reg <= {sbySync_reg[0], standby};
			modeMeta_reg <= detMode;
			mode_reg <= modeMeta_reg;
		end
	end

	assign startPulse = tglSync_reg[2] ^ tglSync_reg[1];
	assign enabled = (mode_reg != `RDC_LVL_L3);

	// detections needed: L0 two, L1 three, L2 one
	always_comb begin
		case (mode_reg)
			`RDC_LVL_L0: need = 2'h2;
			`RDC_LVL_L1: need = 2'h3;
			default: need = 2'h1;
		endcase
	end

	// detect sequence; an invalid probe restarts the count
	always_ff @(posedge clk_link or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= RDC_DET_IDLE;
			hits_reg <= 2'h0;
		end else if (sbySync_reg[1] || !enabled) begin
			state_reg <= RDC_DET_IDLE;
			hits_reg <= 2'h0;
		end else begin
			case (state_reg)
				RDC_DET_IDLE: begin
					if (startPulse) begin
						state_reg <= RDC_DET_PROBE;
						hits_reg <= 2'h0;
					end
				end
				RDC_DET_PROBE: begin
					if (attempt && !found) begin
						hits_reg <= 2'h0;
					end else if (attempt && hits_reg == need - 2'h1) begin
						state_reg <= RDC_DET_DONE;
					end else if (attempt) begin
						hits_reg <= hits_reg + 2'h1;
					end
				end
				RDC_DET_DONE: begin
					if (startPulse) begin
						state_reg <= RDC_DET_PROBE;
						hits_reg <= 2'h0;
					end
				end
				default: state_reg <= RDC_DET_IDLE;
			endcase
		end
	end

	// hi-z until detected, 50 ohm after; 50 ohm when disabled unless in standby
	always_ff @(posedge clk_link or negedge arst_n) begin
		if (!arst_n) begin
			termOn <= 1'b0;
			present <= 1'b0;
		end else begin
			termOn <= !sbySync_reg[1] &&
				(!enabled || state_reg == RDC_DET_DONE);
			present <= !sbySync_reg[1] && enabled &&
				state_reg == RDC_DET_DONE;
		end
	end

	chk_term_before_detect: assert property (
		@(posedge clk_link) disable iff (!arst_n)
		(enabled && state_reg != RDC_DET_DONE) |=> !termOn)
		else $error("termination on before detection");

	chk_buffer_always_on: assert property (
		@(posedge clk_link) disable iff (!arst_n)
		(!enabled && !sbySync_reg[1]) [*2] |-> termOn)
		else $error("disabled detect lost 50 ohm");

	chk_detect_count: assert property (
		@(posedge clk_link) disable iff (!arst_n)
		(state_reg == RDC_DET_PROBE && attempt && found &&
		hits_reg == need - 2'h1 && !sbySync_reg[1] && enabled)
		|=> state_reg == RDC_DET_DONE ##1 termOn)
		else $error("detect count did not finish");

endmodule // rdc_rx_detect

// ### rdc_top.sv
// Purpose: configuration source, eeprom self-load, power-on stretch
//          and receiver detect control of a four-channel redriver
// Assumes: straps arrive as three-comparator thermometer codes
// Notes: detect logic runs on clk_link, the rest on clk_sys
//
// Operation
// - load done within 4 or 7 ms
// - load time scales with chained devices
// - stretch reset 30 ms, then latch address
// - channels keep independent state
// - exactly one configuration source
// - eeprom load acts as smbus master
// - pin mode index is four hi plus lo
// - slave and master modes use register writes
// - detect starts at power-up, pins, write; pins restart it in pin mode only
// - L0 strap needs two valid detections
// - L1 strap needs three valid detections
// - L2 strap needs one valid detection
// - hi-z before detection, 50 ohm after
// - eeprom mode idles until load request low
// - after good read, done low, become slave
// - eeprom address byte is A0
// - L3 strap disables detect, 50 ohm unless in standby
`timescale 1ns/1ps
`include "rdc_defines.svh"
module rdc_top #(
	parameter int NUM_CHAN = 4,
	parameter int POR_CYCLES = `RDC_POR_MS * (`RDC_CLK_HZ / 1000),
	parameter int LOAD_C_CYCLES =
		`RDC_LOAD_COMMON_MS * (`RDC_CLK_HZ / 1000),
	parameter int LOAD_N_CYCLES =
		`RDC_LOAD_NONCOMMON_MS * (`RDC_CLK_HZ / 1000)
) (
	// clocks and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic clk_link,
	// four-level straps, thermometer coded
	input wire logic [2:0] eqAddrStrapHi,
	input wire logic [2:0] eqAddrStrapLo,
	input wire logic [2:0] configSourceStrap,
	input wire logic [2:0] rxDetectStrap,
	// power-down pins
	input wire logic powerDownA,
	input wire logic powerDownB,
	// daisy chain handshake
	input wire logic loadRequestN,
	output logic loadDoneN,
	// smbus master byte engine
	output rdc_pkg::rdc_ee_req_t eeReq,
	input wire rdc_pkg::rdc_ee_rsp_t eeRsp,
	// smbus slave register writes
	input wire rdc_pkg::rdc_slv_wr_t slvWr,
	// status
	output logic porDone,
	output logic [7:0] slaveAddr,
	output rdc_pkg::rdc_src_t activeSource,
	output logic masterActive,
	output logic loadTimeout,
	output logic [4*NUM_CHAN-1:0] chanEq,
	// detect, link domain probes and termination
	input wire logic [NUM_CHAN-1:0] detAttempt,
	input wire logic [NUM_CHAN-1:0] detFound,
	output logic [NUM_CHAN-1:0] termOn,
	// detect result, system domain
	output logic [NUM_CHAN-1:0] rxPresent
);
	import rdc_pkg::*;

	// synchronisers for pins
	logic [2:0] hiMeta_reg, hiSync_reg;
	logic [2:0] loMeta_reg, loSync_reg;
	logic [2:0] srcMeta_reg, srcSync_reg;
	logic [2:0] detMeta_reg, detSync_reg;
	logic [1:0] pdA_reg, pdB_reg; // two-stage power-down
	logic [1:0] req_reg; // two-stage load request
	logic pdAOld_reg, pdBOld_reg; // edge history
	// power-on stretch
	logic [31:0] porCnt_reg;
	logic porDone_reg;
	// latched strap codes
	logic [1:0] hiCode_reg, loCode_reg, detCode_reg;
	rdc_src_t src_reg;
	// eeprom sequencer
	rdc_ee_state_t eeState_reg;
	logic [2:0] byteCnt_reg; // next data byte address
	logic common_reg; // header says one setting for all
	logic [31:0] loadTimer_reg, budget; // cycles spent and allowed
	logic [2:0] lastByte;
	// per channel equalizer setting and detect toggles
	logic [3:0] eq_reg [NUM_CHAN];
	logic [NUM_CHAN-1:0] startTgl_reg, standby, present;
	logic [NUM_CHAN-1:0] presMeta_reg, presSync_reg;
	logic trigAll, slaveWrOk, pdAFall, pdBFall, porRise;

	// thermometer to level code, L0..L3 as 0..3
	function automatic logic [1:0] lvlCode(input logic [2:0] t);
		case (t)
			3'b111: lvlCode = `RDC_LVL_L3;
			3'b011: lvlCode = `RDC_LVL_L2;
			3'b001: lvlCode = `RDC_LVL_L1;
			default: lvlCode = `RDC_LVL_L0;
		endcase
	endfunction

	// pins pass two flip-flops before anything reads them
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			hiMeta_reg <= 3'h0;
			hiSync_reg <= 3'h0;
			loMeta_reg <= 3'h0;
			loSync_reg <= 3'h0;
			srcMeta_reg <= 3'h0;
			srcSync_reg <= 3'h0;
			detMeta_reg <= 3'h0;
			detSync_reg <= 3'h0;
			pdA_reg <= 2'h3;
			pdB_reg <= 2'h3;
			req_reg <= 2'h3;
			pdAOld_reg <= 1'b1;
			pdBOld_reg <= 1'b1;
		end else begin
			hiMeta_reg <= eqAddrStrapHi;
			hiSync_reg <= hiMeta_reg;
			loMeta_reg <= eqAddrStrapLo;
			loSync_reg <= loMeta_reg;
			srcMeta_reg <= configSourceStrap;
			srcSync_reg <= srcMeta_reg;
			detMeta_reg <= rxDetectStrap;
			detSync_reg <= detMeta_reg;
			pdA_reg <= {pdA_reg[0], powerDownA};
			pdB_reg <= {pdB_reg[0], powerDownB};
			req_reg <= {req_reg[0], loadRequestN};
			pdAOld_reg <= pdA_reg[1]; // edge history, second stage only
			pdBOld_reg <= pdB_reg[1];
		end
	end

	// power-on stretch; the host must wait for porDone
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			porCnt_reg <= 32'h0;
			porDone_reg <= 1'b0;
		end else if (!porDone_reg) begin
			if (porCnt_reg == 32'(POR_CYCLES - 1)) begin
				porDone_reg <= 1'b1;
			end
			porCnt_reg <= porCnt_reg + 32'h1;
		end
	end

	assign porRise = !porDone_reg && porCnt_reg == 32'(POR_CYCLES - 1);
	// straps sampled once, as the stretch ends
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			hiCode_reg <= `RDC_LVL_L0;
			loCode_reg <= `RDC_LVL_L0;
			detCode_reg <= `RDC_LVL_L0;
			src_reg <= RDC_SRC_PIN;
			slaveAddr <= `RDC_ADDR_RESET;
		end else if (porRise) begin
			hiCode_reg <= lvlCode(hiSync_reg);
			loCode_reg <= lvlCode(loSync_reg);
			detCode_reg <= lvlCode(detSync_reg);
			// one source only; L2 falls back to pins
			case (lvlCode(srcSync_reg))
				`RDC_LVL_L1: src_reg <= RDC_SRC_EEPROM;
				`RDC_LVL_L3: src_reg <= RDC_SRC_SLAVE;
				default: src_reg <= RDC_SRC_PIN;
			endcase
			slaveAddr <= `RDC_SLAVE_BASE +
				{3'h0, lvlCode(hiSync_reg), lvlCode(loSync_reg), 1'b0};
		end
	end

	// the budget is unknown until the header arrives: assume the longer
	assign budget = (eeState_reg == RDC_EE_DATA && common_reg) ?
		32'(LOAD_C_CYCLES) : 32'(LOAD_N_CYCLES);
	assign lastByte = common_reg ? 3'h1 : 3'(NUM_CHAN);

	// eeprom self-load: master until done, then slave
	// chained devices each wait for the previous done, so the total
	// load time grows with the chain length
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			eeState_reg <= RDC_EE_IDLE;
			byteCnt_reg <= 3'h1;
			common_reg <= 1'b0;
			loadTimer_reg <= 32'h0;
		end else begin
			case (eeState_reg)
				RDC_EE_IDLE: begin
					loadTimer_reg <= 32'h0;
					if (porDone_reg && src_reg != RDC_SRC_EEPROM) begin
						eeState_reg <= RDC_EE_OFF;
					end else if (porDone_reg && !req_reg[1]) begin
						eeState_reg <= RDC_EE_HDR;
					end
				end
				RDC_EE_HDR: begin
					loadTimer_reg <= loadTimer_reg + 32'h1;
					if (eeRsp.ack) begin
						common_reg <= eeRsp.data[`RDC_HDR_COMMON_BIT];
						byteCnt_reg <= 3'h1;
						eeState_reg <= RDC_EE_DATA;
					end else if (loadTimer_reg >= budget - 32'h1) begin
						eeState_reg <= RDC_EE_FAIL;
					end
				end
				RDC_EE_DATA: begin
					loadTimer_reg <= loadTimer_reg + 32'h1;
					if (eeRsp.ack && byteCnt_reg == lastByte) begin
						eeState_reg <= RDC_EE_DONE;
					end else if (eeRsp.ack) begin
						byteCnt_reg <= byteCnt_reg + 3'h1;
					end else if (loadTimer_reg >= budget - 32'h1) begin
						eeState_reg <= RDC_EE_FAIL;
					end
				end
				RDC_EE_DONE: eeState_reg <= RDC_EE_DONE;
				RDC_EE_FAIL: eeState_reg <= RDC_EE_FAIL;
				RDC_EE_OFF: eeState_reg <= RDC_EE_OFF;
				default: eeState_reg <= RDC_EE_IDLE;
			endcase
		end
	end

	// read request held until the engine acknowledges
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			eeReq <= '0;
		end else begin
			eeReq.valid <= (eeState_reg == RDC_EE_HDR ||
				eeState_reg == RDC_EE_DATA) && !eeRsp.ack;
			eeReq.devAddr <= `RDC_EEPROM_ADDR;
			eeReq.byteAddr <= (eeState_reg == RDC_EE_DATA) ?
				{5'h0, byteCnt_reg} : `RDC_EE_HDR_ADDR;
		end
	end

	// status flags from the load sequencer
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			loadDoneN <= 1'b1;
			masterActive <= 1'b0;
			loadTimeout <= 1'b0;
		end else begin
			loadDoneN <= !(eeState_reg == RDC_EE_DONE);
			masterActive <= eeState_reg == RDC_EE_HDR ||
				eeState_reg == RDC_EE_DATA;
			loadTimeout <= eeState_reg == RDC_EE_FAIL;
		end
	end

	// after a good load the eeprom device answers as a slave too
	assign slaveWrOk = porDone_reg && slvWr.valid &&
		(src_reg == RDC_SRC_SLAVE || eeState_reg == RDC_EE_DONE);
	assign trigAll = porDone_reg && slvWr.detTrig &&
		(src_reg == RDC_SRC_SLAVE || eeState_reg == RDC_EE_DONE);
	assign pdAFall = pdAOld_reg && !pdA_reg[1];
	assign pdBFall = pdBOld_reg && !pdB_reg[1];

	// result levels back into the system domain
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			presMeta_reg <= '0;
			presSync_reg <= '0;
		end else begin
			presMeta_reg <= present;
			presSync_reg <= presMeta_reg;
		end
	end
	assign rxPresent = presSync_reg;

	// per channel state; channels 0..1 follow A, the rest B
	// tying A and B together gives one control for the whole link
	for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
		logic pdLvl;
		logic pdFall;
		assign pdLvl = (c < NUM_CHAN / 2) ? pdA_reg[1] : pdB_reg[1];
		assign pdFall = (c < NUM_CHAN / 2) ? pdAFall : pdBFall;
		assign standby[c] = pdLvl || !porDone_reg;

		// equalizer setting of this channel only
		always_ff @(posedge clk_sys or negedge arst_n) begin
			if (!arst_n) begin
				eq_reg[c] <= `RDC_EQ_RESET;
			end else if (src_reg == RDC_SRC_PIN && porDone_reg) begin
				eq_reg[c] <= {hiCode_reg, loCode_reg};
			end else if (eeState_reg == RDC_EE_DATA && eeRsp.ack &&
				(common_reg || byteCnt_reg == 3'(c + 1))) begin
				eq_reg[c] <= eeRsp.data[`RDC_EQ_LSB +: 4];
			end else if (slaveWrOk && slvWr.chan == 2'(c)) begin
				eq_reg[c] <= slvWr.eq;
			end
		end
		assign chanEq[4*c +: 4] = eq_reg[c];

		// start events become a toggle for the link domain
		always_ff @(posedge clk_sys or negedge arst_n) begin
			if (!arst_n) begin
				startTgl_reg[c] <= 1'b0;
			end else if (porRise || trigAll ||
				(pdFall && src_reg == RDC_SRC_PIN && porDone_reg)) begin
				startTgl_reg[c] <= !startTgl_reg[c];
			end
		end

		rdc_rx_detect u_det (
			.clk_link(clk_link),
			.arst_n(arst_n),
			.startTgl(startTgl_reg[c]),
			.standby(standby[c]),
			.detMode(detCode_reg),
			.attempt(detAttempt[c]),
			.found(detFound[c]),
			.termOn(termOn[c]),
			.present(present[c])
		);
	end

	assign porDone = porDone_reg;
	assign activeSource = src_reg;

	// hi strap weighs eight, lo strap two, in the 8-bit address byte
	chk_addr_latch: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		$rose(porDone_reg) |-> slaveAddr ==
		8'(`RDC_SLAVE_BASE + 8 * hiCode_reg + 2 * loCode_reg))
		else $error("slave address not latched from straps");
	chk_pin_index: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		(porDone_reg && src_reg == RDC_SRC_PIN) |=>
		eq_reg[0] == 4'(4 * hiCode_reg + loCode_reg))
		else $error("pin mode index wrong");
	chk_idle_wait: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		(eeState_reg == RDC_EE_IDLE && req_reg[1]) |=>
		(eeState_reg != RDC_EE_HDR && !eeReq.valid))
		else $error("eeprom read without load request");
	chk_ee_address: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		eeReq.valid |-> eeReq.devAddr == 8'hA0)
		else $error("eeprom address byte wrong");
	chk_done_good: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		$fell(loadDoneN) |-> $past(eeState_reg, 2) == RDC_EE_DATA &&
		!masterActive)
		else $error("load done without finished read");
	chk_load_budget: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		masterActive |-> loadTimer_reg <= 32'(LOAD_N_CYCLES))
		else $error("load exceeded its time budget");
	chk_pre_por_quiet: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		!porDone_reg |=> $stable(chanEq) && !masterActive)
		else $error("activity before power-on stretch end");
	chk_one_source: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		(src_reg != RDC_SRC_EEPROM && porDone_reg) |-> !eeReq.valid)
		else $error("eeprom read outside eeprom mode");

endmodule // rdc_top

// ### rdc_ee_model.sv
// Purpose: behavioural configuration eeprom behind the byte engine
// Assumes: one read outstanding, answered by a one-cycle ack pulse
// Notes: mute stands for a missing eeprom, dly for a slow one
`timescale 1ns/1ps
`include "rdc_defines.svh"
module rdc_ee_model (
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// read request in, answer out
	input wire rdc_pkg::rdc_ee_req_t eeReq,
	output rdc_pkg::rdc_ee_rsp_t eeRsp,
	// misbehaviour controls
	input wire logic mute,
	input wire logic [3:0] dly
);
	import rdc_pkg::*;
	logic [7:0] mem [0:255]; // image, filled by the bench
	logic [3:0] waitCnt; // cycles spent on this request
	logic busy; // answered, waiting for valid to drop
	logic [7:0] noise; // data content between answers
	// answer engine; data never keeps a stale byte, so a design that
	// samples outside the ack pulse sees garbage
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			eeRsp <= '0;
			waitCnt <= 4'h0;
			busy <= 1'b0;
			noise <= 8'hA5;
		end else begin
			noise <= ~noise + 8'h3B;
			eeRsp <= '{1'b0, noise};
			if (!eeReq.valid) begin
				// request gone: ready for the next
				busy <= 1'b0;
				waitCnt <= 4'h0;
			end else if (!busy && !mute &&
				eeReq.devAddr == `RDC_EEPROM_ADDR) begin
				if (waitCnt == dly) begin
					eeRsp <= '{1'b1, mem[eeReq.byteAddr]};
					busy <= 1'b1;
				end else begin
					waitCnt <= waitCnt + 4'h1;
				end
			end
		end
	end
endmodule // rdc_ee_model

// ### tb_rdc_top.sv
// Purpose: self-checking bench of the redriver control top
// Assumes: shortened power-on and load budgets via parameters
// Notes: expectations come from integer models of straps and images
`timescale 1ns/1ps
`include "rdc_defines.svh"
module tb_rdc_top;
	import rdc_pkg::*;
	localparam int POR = 20; // shortened reset stretch
	localparam int LC = 200; // common image budget
	localparam int LN = 300; // per-channel image budget
	logic clk_sys, clk_link, arst_n, powerDownA, powerDownB;
	logic loadRequestN, loadDoneN, porDone, masterActive, loadTimeout;
	logic mute; // eeprom silent
	logic [3:0] dly; // eeprom answer delay
	logic [2:0] eqAddrStrapHi, eqAddrStrapLo;
	logic [2:0] configSourceStrap, rxDetectStrap;
	rdc_ee_req_t eeReq;
	rdc_ee_rsp_t eeRsp;
	rdc_slv_wr_t slvWr;
	rdc_src_t activeSource;
	logic [7:0] slaveAddr;
	logic [15:0] chanEq, r, lfsr;
	logic [3:0] termOn, rxPresent, detAttempt, detFound;
	logic [3:0] expEq [4]; // model of the per-channel index
	int fails, n_compared;
	int srcT[4] = '{0, 1, 0, 2}; // source per strap level, L2 is pin
	int needT[4] = '{2, 3, 1, 0}; // valid detections per strap level

	rdc_top #(.POR_CYCLES(POR), .LOAD_C_CYCLES(LC), .LOAD_N_CYCLES(LN))
		u_dut (.*);
	rdc_ee_model u_ee (.*);

	// clocks; the link runs unrelated in phase
	initial begin
		clk_sys = 0;
		forever #50 clk_sys = ~clk_sys;
	end
	initial begin
		clk_link = 0;
		#3.7;
		forever #6 clk_link = ~clk_link;
	end

	// lfsr step
	function automatic logic [15:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction
	// level to comparator thermometer code
	function automatic logic [2:0] th(input int l);
		return 3'h7 >> (3 - l);
	endfunction

	// compare a value
	task automatic chkV(input string n, input logic [15:0] e, g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	// compare a flag
	task automatic chkF(input string n, input logic e, g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %b seen %b", n, e, g);
		end
	endtask
	// compare all channel indices with the model
	task automatic chkEq();
		logic [15:0] e;
		for (int c = 0; c < 4; c++) e[4*c+:4] = expEq[c];
		chkV("chanEq", e, chanEq);
	endtask
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// reset with strap levels, then time the power-on stretch
	task automatic boot(input int src, det, hi, lo);
		@(negedge clk_sys);
		arst_n = 0;
		configSourceStrap = th(src);
		rxDetectStrap = th(det);
		eqAddrStrapHi = th(hi);
		eqAddrStrapLo = th(lo);
		loadRequestN = 1;
		foreach (expEq[c]) expEq[c] = 4'h0;
		repeat (10) @(negedge clk_sys);
		arst_n = 1;
		repeat (POR - 1) @(negedge clk_sys);
		chkF("porDone", 0, porDone);
		@(negedge clk_sys);
		chkF("porDone", 1, porDone);
		chkV("slaveAddr", 8'h30 + 2 * (4 * hi + lo), slaveAddr);
		chkV("source", srcT[src], activeSource);
	endtask
	// one slave write pulse, only after the stretch has ended
	task automatic wr(input int c, input logic [3:0] e, input logic t);
		@(negedge clk_sys);
		slvWr = '{1'b1, c[1:0], e, t};
		@(negedge clk_sys);
		slvWr = '0;
		@(negedge clk_sys);
	endtask
	// one probe on the link side, hit or miss
	task automatic probe(input logic [3:0] ch, input logic hit);
		@(negedge clk_link);
		detAttempt = ch;
		detFound = hit ? ch : 4'h0;
		@(negedge clk_link);
		detAttempt = 4'h0;
		detFound = 4'h0;
		repeat (3) @(negedge clk_link);
	endtask
	// detection count, miss in mid-run, power-down restart of ch0,1
	task automatic detect(input int lvl);
		int need;
		need = needT[lvl];
		repeat (4) @(negedge clk_sys);
		if (lvl == 3) begin
			chkV("termOn", 4'hF, termOn);
		end else begin
			repeat (need - 1) probe(4'hF, 1);
			probe(4'hF, 0);
			repeat (need - 1) probe(4'hF, 1);
			repeat (4) @(negedge clk_sys);
			chkV("termOn", 4'h0, termOn);
			chkV("rxPresent", 4'h0, rxPresent);
			probe(4'hF, 1);
			repeat (4) @(negedge clk_sys);
			chkV("termOn", 4'hF, termOn);
			chkV("rxPresent", 4'hF, rxPresent);
		end
		powerDownA = 1;
		repeat (4) @(negedge clk_sys);
		chkV("termOn", 4'hC, termOn);
		powerDownA = 0;
		repeat (4) @(negedge clk_sys);
		chkV("termOn", lvl == 3 ? 4'hF : 4'hC, termOn);
		repeat (need) probe(4'h3, 1);
		repeat (4) @(negedge clk_sys);
		chkV("termOn", 4'hF, termOn);
		// both power-down pins driven as one signal for the whole link
		powerDownA = 1;
		powerDownB = 1;
		repeat (4) @(negedge clk_sys);
		chkV("termOn", 4'h0, termOn);
		chkV("rxPresent", 4'h0, rxPresent);
		powerDownA = 0;
		powerDownB = 0;
		repeat (4) @(negedge clk_sys);
		chkV("termOn", lvl == 3 ? 4'hF : 4'h0, termOn);
	endtask
	// self-load from the eeprom model, then a slave write
	task automatic eeLoad(input logic common, input logic quiet);
		int n, lim;
		boot(1, 3, 0, 1);
		mute = quiet;
		r = rnd();
		dly = r[3:0];
		u_ee.mem[0] = {r[15:9], common};
		for (int i = 1; i < 5; i++) u_ee.mem[i] = rnd();
		lim = quiet ? 2 * LN + 20 : (common ? LC : LN);
		repeat (30) @(negedge clk_sys);
		chkF("eeReq.valid", 0, eeReq.valid);
		chkF("loadDoneN", 1, loadDoneN);
		loadRequestN = 0;
		n = 0;
		while (loadDoneN !== 1'b0 && n < lim) begin
			@(negedge clk_sys);
			n++;
			if (eeReq.valid === 1'b1)
				chkV("devAddr", `RDC_EEPROM_ADDR, eeReq.devAddr);
		end
		if (n >= lim && !quiet) begin
			fails++;
			finish_test();
		end
		for (int c = 0; c < 4; c++)
			if (!quiet) expEq[c] = u_ee.mem[common ? 1 : 1 + c][3:0];
		@(negedge clk_sys);
		chkF("loadDoneN", quiet, loadDoneN);
		chkF("loadTimeout", quiet, loadTimeout);
		chkF("masterActive", 0, masterActive);
		chkEq();
		r = rnd();
		wr(r[1:0], r[7:4], 0);
		if (!quiet) expEq[r[1:0]] = r[7:4];
		chkEq();
	endtask

	// main sequence
	initial begin
		arst_n = 0;
		powerDownA = 0;
		powerDownB = 0;
		loadRequestN = 1;
		mute = 0;
		dly = 4'h0;
		slvWr = '0;
		detAttempt = 4'h0;
		detFound = 4'h0;
		eqAddrStrapHi = 3'h0;
		eqAddrStrapLo = 3'h0;
		configSourceStrap = 3'h0;
		rxDetectStrap = 3'h0;
		fails = 0;
		n_compared = 0;
		lfsr = 16'hEBCA;
		// pin mode, every detect strap level
		for (int k = 0; k < 4; k++) begin
			r = rnd();
			boot(k[0] ? 2 : 0, k, r[1:0], r[3:2]);
			@(negedge clk_sys);
			foreach (expEq[c]) expEq[c] = 4 * r[1:0] + r[3:2];
			chkEq();
			wr(1, r[7:4], 0);
			chkEq();
			detect(k);
		end
		eeLoad(1, 0);
		eeLoad(0, 0);
		// slave mode: independent channels, detect restart by write
		boot(3, 2, 2, 3);
		for (int c = 0; c < 4; c++) begin
			r = rnd();
			wr(c, r[3:0], 0);
			expEq[c] = r[3:0];
			chkEq();
		end
		repeat (4) @(negedge clk_sys);
		probe(4'hF, 1);
		wr(0, 4'h9, 1);
		expEq[0] = 4'h9;
		chkV("termOn", 4'h0, termOn);
		probe(4'hF, 1);
		repeat (4) @(negedge clk_sys);
		chkV("termOn", 4'hF, termOn);
		chkEq();
		eeLoad(0, 1);
		finish_test();
	end
endmodule // tb_rdc_top
